// ---- hdl/adrv_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing figures of the antenna driver block
// Assumes: 32-bit APB, one register per aligned word
// Notes: Definitions only
`ifndef ADRV_CONSTS_SVH
`define ADRV_CONSTS_SVH

// Register byte offsets
`define ADRV_OFS_CONTROL 8'h00
`define ADRV_OFS_P_CW 8'h04
`define ADRV_OFS_P_MOD 8'h08
`define ADRV_OFS_N_COND 8'h0C
`define ADRV_OFS_FRAMING 8'h10
`define ADRV_OFS_TX_ROUTE 8'h14
`define ADRV_OFS_RX_ROUTE 8'h18
`define ADRV_OFS_STATUS 8'h1C

// Antenna driver control fields
`define ADRV_CTL_FIRST_EN 0
`define ADRV_CTL_SECOND_EN 1
`define ADRV_CTL_FORCE_ASK 2
`define ADRV_CTL_SECOND_CW 3
`define ADRV_CTL_INV1_ON 4
`define ADRV_CTL_INV1_OFF 5
`define ADRV_CTL_INV2_ON 6
`define ADRV_CTL_INV2_OFF 7
`define ADRV_CTL_W 8

// Conductance fields
`define ADRV_P_COND_W 6
`define ADRV_N_COND_W 4
`define ADRV_N_CW_LSB 4
`define ADRV_N_MOD_LSB 0

// Framing fields
`define ADRV_FRM_FRAMING_LSB 0
`define ADRV_FRM_FRAMING_W 2
`define ADRV_FRM_RATE_LSB 4
`define ADRV_FRM_RATE_W 3

// Route select fields
`define ADRV_TXR_DRIVER_LSB 4
`define ADRV_TXR_DRIVER_W 2
`define ADRV_TXR_OUTSEL_LSB 0
`define ADRV_TXR_OUTSEL_W 4
`define ADRV_RXR_UART_LSB 0
`define ADRV_RXR_UART_W 2

// Reset values
`define ADRV_RST_CONTROL 8'h00
`define ADRV_RST_P_CW 6'h3F
`define ADRV_RST_P_MOD 6'h20
`define ADRV_RST_N_COND 8'h88
`define ADRV_RST_FRAMING 7'h00
`define ADRV_RST_TX_ROUTE 6'h10
`define ADRV_RST_RX_ROUTE 2'h0

// Timing figures in kHz, and the crystal divide ratio
`define ADRV_XTAL_KHZ 27120
`define ADRV_CARRIER_KHZ 13560
`define ADRV_XTAL_DIV 2

`endif

// ---- hdl/adrv_pkg.sv ----
// Purpose: Types of the antenna driver output select block
// Assumes: Constants come from adrv_consts.svh
// Notes: Driver and receive route selections are enumerations
package adrv_pkg;

    typedef enum logic [1:0] {
        DRV_NONE = 2'h0,
        DRV_INTERNAL = 2'h1,
        DRV_SERIAL_PIN = 2'h2,
        DRV_INTERNAL_ALT = 2'h3
    } driver_sel_t;

    typedef enum logic [1:0] {
        RXSRC_LOW = 2'h0,
        RXSRC_SERIAL_PIN = 2'h1,
        RXSRC_ANALOG = 2'h2,
        RXSRC_ANALOG_ALT = 2'h3
    } rx_src_t;

endpackage : adrv_pkg

// ---- hdl/carrier_divider.sv ----
// Purpose: Divides the crystal clock by two into the carrier and its inverse
// Assumes: i_xtal_clk is an unrelated pin, well below half of i_mclk
// Notes: Each rising crystal edge toggles the carrier
`timescale 1ns/1ps
`include "adrv_consts.svh"

module carrier_divider (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_xtal_clk,
    output logic o_carrier_clk,
    output logic o_carrier_clk_inverted
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic carrier_reg;

    // Two-stage synchroniser, then edge history
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= i_xtal_clk;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Toggle per crystal rising edge halves the rate
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            carrier_reg <= 1'b0;
        end else if (sync2_reg && !prev_reg) begin
            carrier_reg <= ~carrier_reg;
        end
    end

    assign o_carrier_clk = carrier_reg;
    assign o_carrier_clk_inverted = ~carrier_reg;
endmodule : carrier_divider

// ---- hdl/antenna_driver_output_select.sv ----
// Purpose: Antenna driver output and conductance selection with APB registers
// Assumes: Envelope and encoder signals are on i_mclk; pins are synchronised here
// Notes: Disabled outputs are held low with zero conductance
`timescale 1ns/1ps
`include "adrv_consts.svh"

// Functional notes
// - Antenna outputs carry carrier modulated by envelope
// - Carrier is crystal clock halved
// - Inversion bit selects inverted carrier
// - Enable low holds outputs low, zero conductance
// - Envelope one picks CW, zero modulation
// - P conductance: separate CW and modulation registers
// - N conductance: one register, two nibbles
// - One driver enabled: shared settings for both
// - Second CW bit forces CW carrier
// - Control register configures both output pins
// - Framing and route registers set rate, drivers
// - Serial switch routes signals to pins
module antenna_driver_output_select #(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_xtal_clk,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_envelope,
    input wire logic i_encoded_tx,
    input wire logic i_analog_rx,
    input wire logic i_serial_switch_in_pin,
    output logic o_serial_switch_out_pin,
    output logic o_digital_rx,
    output logic o_antenna_out_first,
    output logic o_antenna_out_second,
    output logic [`ADRV_P_COND_W-1:0] o_first_p_array_conductance,
    output logic [`ADRV_N_COND_W-1:0] o_first_n_array_conductance,
    output logic [`ADRV_P_COND_W-1:0] o_second_p_array_conductance,
    output logic [`ADRV_N_COND_W-1:0] o_second_n_array_conductance,
    output logic [`ADRV_FRM_RATE_W-1:0] o_tx_rate,
    output logic [`ADRV_FRM_FRAMING_W-1:0] o_tx_framing
);
    localparam int CARRIER_RATIO = `ADRV_XTAL_KHZ / `ADRV_CARRIER_KHZ;

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
        $error("ADDR_W must be 8 to 32");
    end
    if (CARRIER_RATIO != `ADRV_XTAL_DIV) begin : g_ratio_check
        $error("Carrier must be the crystal clock halved");
    end

    logic [`ADRV_CTL_W-1:0] antenna_driver_control_reg;
    logic [`ADRV_P_COND_W-1:0] p_cw_conductance_reg;
    logic [`ADRV_P_COND_W-1:0] p_mod_conductance_reg;
    logic [2*`ADRV_N_COND_W-1:0] n_conductance_reg;
    logic [`ADRV_FRM_RATE_W+`ADRV_FRM_FRAMING_W+1:0] transmit_framing_reg;
    logic [`ADRV_TXR_DRIVER_W+`ADRV_TXR_OUTSEL_W-1:0] transmit_route_select_reg;
    logic [`ADRV_RXR_UART_W-1:0] receive_route_select_reg;
    logic [31:0] prdata_reg;
    logic slverr_reg;
    logic [31:0] rdata_next;
    logic hit_next;

    logic carrier_clk;
    logic carrier_clk_inverted;
    logic serial_in_sync1_reg;
    logic serial_in_sync2_reg;

    logic carrier_out_enable;
    logic second_out_enable;
    logic full_depth_ask_force;
    logic second_out_continuous_wave;
    logic [1:0] invert_on;
    logic [1:0] invert_off;
    logic [1:0] out_enable;
    logic [1:0] force_cw;
    logic [`ADRV_N_COND_W-1:0] n_cw_conductance;
    logic [`ADRV_N_COND_W-1:0] n_mod_conductance;
    adrv_pkg::driver_sel_t driver_sel;
    adrv_pkg::rx_src_t rx_src;
    logic [`ADRV_TXR_OUTSEL_W-1:0] out_sel;
    logic envelope_sel;

    logic [1:0] pin_next;
    logic [1:0] pin_reg;
    logic [1:0] cw_next;
    logic [1:0] cw_reg;
    logic [`ADRV_P_COND_W-1:0] p_cond_next [2];
    logic [`ADRV_N_COND_W-1:0] n_cond_next [2];
    logic [`ADRV_P_COND_W-1:0] p_cond_reg [2];
    logic [`ADRV_N_COND_W-1:0] n_cond_reg [2];
    logic serial_out_next;
    logic serial_out_reg;
    logic digital_rx_next;
    logic digital_rx_reg;

    logic wr_en;
    logic setup_phase;

    carrier_divider u_carrier_divider (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_xtal_clk(i_xtal_clk),
        .o_carrier_clk(carrier_clk),
        .o_carrier_clk_inverted(carrier_clk_inverted)
    );

    // APB phases
    assign setup_phase = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && i_pwrite && !slverr_reg;

    // Register writes
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            antenna_driver_control_reg <= `ADRV_RST_CONTROL;
            p_cw_conductance_reg <= `ADRV_RST_P_CW;
            p_mod_conductance_reg <= `ADRV_RST_P_MOD;
            n_conductance_reg <= `ADRV_RST_N_COND;
            transmit_framing_reg <= `ADRV_RST_FRAMING;
            transmit_route_select_reg <= `ADRV_RST_TX_ROUTE;
            receive_route_select_reg <= `ADRV_RST_RX_ROUTE;
        end else if (wr_en) begin
            unique case (i_paddr[7:0])
                `ADRV_OFS_CONTROL: begin
                    antenna_driver_control_reg <= i_pwdata[`ADRV_CTL_W-1:0];
                end
                `ADRV_OFS_P_CW: begin
                    p_cw_conductance_reg <= i_pwdata[`ADRV_P_COND_W-1:0];
                end
                `ADRV_OFS_P_MOD: begin
                    p_mod_conductance_reg <= i_pwdata[`ADRV_P_COND_W-1:0];
                end
                `ADRV_OFS_N_COND: begin
                    n_conductance_reg <= i_pwdata[2*`ADRV_N_COND_W-1:0];
                end
                `ADRV_OFS_FRAMING: begin
                    transmit_framing_reg <= i_pwdata[`ADRV_FRM_RATE_W+`ADRV_FRM_FRAMING_W+1:0];
                end
                `ADRV_OFS_TX_ROUTE: begin
                    transmit_route_select_reg <= i_pwdata[`ADRV_TXR_DRIVER_W+`ADRV_TXR_OUTSEL_W-1:0];
                end
                `ADRV_OFS_RX_ROUTE: begin
                    receive_route_select_reg <= i_pwdata[`ADRV_RXR_UART_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data and decode for the current address
    always_comb begin
        rdata_next = 32'h0000_0000;
        hit_next = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:5] == '0);
        unique case (i_paddr[4:0])
            5'h00: begin
                rdata_next[`ADRV_CTL_W-1:0] = antenna_driver_control_reg;
            end
            5'h04: begin
                rdata_next[`ADRV_P_COND_W-1:0] = p_cw_conductance_reg;
            end
            5'h08: begin
                rdata_next[`ADRV_P_COND_W-1:0] = p_mod_conductance_reg;
            end
            5'h0C: begin
                rdata_next[2*`ADRV_N_COND_W-1:0] = n_conductance_reg;
            end
            5'h10: begin
                rdata_next[`ADRV_FRM_RATE_W+`ADRV_FRM_FRAMING_W+1:0] = transmit_framing_reg;
            end
            5'h14: begin
                rdata_next[`ADRV_TXR_DRIVER_W+`ADRV_TXR_OUTSEL_W-1:0] = transmit_route_select_reg;
            end
            5'h18: begin
                rdata_next[`ADRV_RXR_UART_W-1:0] = receive_route_select_reg;
            end
            5'h1C: begin
                rdata_next[7:0] = {cw_reg, serial_in_sync2_reg, envelope_sel, pin_reg, carrier_clk, 1'b1};
            end
            default: begin
                hit_next = 1'b0;
            end
        endcase
    end

    // Read data and error latched in the setup cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= (i_pwrite || !hit_next) ? 32'h0000_0000 : rdata_next;
            slverr_reg <= !hit_next || (i_pwrite && i_paddr[4:0] == 5'h1C);
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && slverr_reg;

    // Serial switch input pin synchroniser
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            serial_in_sync1_reg <= 1'b0;
            serial_in_sync2_reg <= 1'b0;
        end else begin
            serial_in_sync1_reg <= i_serial_switch_in_pin;
            serial_in_sync2_reg <= serial_in_sync1_reg;
        end
    end

    // Field extraction
    assign carrier_out_enable = antenna_driver_control_reg[`ADRV_CTL_FIRST_EN];
    assign second_out_enable = antenna_driver_control_reg[`ADRV_CTL_SECOND_EN];
    assign full_depth_ask_force = antenna_driver_control_reg[`ADRV_CTL_FORCE_ASK];
    assign second_out_continuous_wave = antenna_driver_control_reg[`ADRV_CTL_SECOND_CW];
    assign invert_on = {antenna_driver_control_reg[`ADRV_CTL_INV2_ON], antenna_driver_control_reg[`ADRV_CTL_INV1_ON]};
    assign invert_off = {antenna_driver_control_reg[`ADRV_CTL_INV2_OFF],
                         antenna_driver_control_reg[`ADRV_CTL_INV1_OFF]};
    assign out_enable = {second_out_enable, carrier_out_enable};
    assign force_cw = {second_out_continuous_wave, 1'b0};
    assign n_cw_conductance = n_conductance_reg[`ADRV_N_CW_LSB+`ADRV_N_COND_W-1:`ADRV_N_CW_LSB];
    assign n_mod_conductance = n_conductance_reg[`ADRV_N_MOD_LSB+`ADRV_N_COND_W-1:`ADRV_N_MOD_LSB];
    assign driver_sel = adrv_pkg::driver_sel_t'(transmit_route_select_reg[`ADRV_TXR_DRIVER_LSB+:`ADRV_TXR_DRIVER_W]);
    assign out_sel = transmit_route_select_reg[`ADRV_TXR_OUTSEL_LSB+:`ADRV_TXR_OUTSEL_W];
    assign rx_src = adrv_pkg::rx_src_t'(receive_route_select_reg[`ADRV_RXR_UART_LSB+:`ADRV_RXR_UART_W]);
    assign o_tx_rate = transmit_framing_reg[`ADRV_FRM_RATE_LSB+:`ADRV_FRM_RATE_W];
    assign o_tx_framing = transmit_framing_reg[`ADRV_FRM_FRAMING_LSB+:`ADRV_FRM_FRAMING_W];

    // Envelope source chosen by the driver route field
    always_comb begin
        unique case (driver_sel)
            adrv_pkg::DRV_NONE: begin
                envelope_sel = 1'b1;
            end
            adrv_pkg::DRV_INTERNAL: begin
                envelope_sel = i_envelope;
            end
            adrv_pkg::DRV_SERIAL_PIN: begin
                envelope_sel = serial_in_sync2_reg;
            end
            adrv_pkg::DRV_INTERNAL_ALT: begin
                envelope_sel = i_envelope;
            end
        endcase
    end

    // Per-output pin and conductance selection
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        always_comb begin
            pin_next[ch] = 1'b0;
            cw_next[ch] = 1'b0;
            p_cond_next[ch] = '0;
            n_cond_next[ch] = '0;
            if (out_enable[ch]) begin
                if (force_cw[ch]) begin
                    cw_next[ch] = 1'b1;
                    pin_next[ch] = invert_on[ch] ? carrier_clk_inverted : carrier_clk;
                end else if (envelope_sel) begin
                    cw_next[ch] = 1'b1;
                    pin_next[ch] = invert_on[ch] ? carrier_clk_inverted : carrier_clk;
                end else if (full_depth_ask_force) begin
                    pin_next[ch] = 1'b0;
                end else begin
                    pin_next[ch] = invert_off[ch] ? carrier_clk_inverted : carrier_clk;
                end
                // Both drivers read the same shared settings
                p_cond_next[ch] = cw_next[ch] ? p_cw_conductance_reg : p_mod_conductance_reg;
                n_cond_next[ch] = cw_next[ch] ? n_cw_conductance : n_mod_conductance;
            end
        end

        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                pin_reg[ch] <= 1'b0;
                cw_reg[ch] <= 1'b0;
                p_cond_reg[ch] <= '0;
                n_cond_reg[ch] <= '0;
            end else begin
                pin_reg[ch] <= pin_next[ch];
                cw_reg[ch] <= cw_next[ch];
                p_cond_reg[ch] <= p_cond_next[ch];
                n_cond_reg[ch] <= n_cond_next[ch];
            end
        end
    end

    assign o_antenna_out_first = pin_reg[0];
    assign o_antenna_out_second = pin_reg[1];
    assign o_first_p_array_conductance = p_cond_reg[0];
    assign o_first_n_array_conductance = n_cond_reg[0];
    assign o_second_p_array_conductance = p_cond_reg[1];
    assign o_second_n_array_conductance = n_cond_reg[1];

    // Serial switch output pin source
    always_comb begin
        unique case (out_sel)
            4'h0: serial_out_next = 1'b0;
            4'h1: serial_out_next = 1'b1;
            4'h2: serial_out_next = envelope_sel;
            4'h3: serial_out_next = carrier_clk;
            4'h4: serial_out_next = i_encoded_tx;
            4'h5: serial_out_next = i_analog_rx;
            4'h6: serial_out_next = pin_reg[0];
            4'h7: serial_out_next = pin_reg[1];
            default: serial_out_next = 1'b0;
        endcase
    end

    // Digital receiver input source
    always_comb begin
        unique case (rx_src)
            adrv_pkg::RXSRC_LOW: begin
                digital_rx_next = 1'b0;
            end
            adrv_pkg::RXSRC_SERIAL_PIN: begin
                digital_rx_next = serial_in_sync2_reg;
            end
            adrv_pkg::RXSRC_ANALOG: begin
                digital_rx_next = i_analog_rx;
            end
            adrv_pkg::RXSRC_ANALOG_ALT: begin
                digital_rx_next = i_analog_rx;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            serial_out_reg <= 1'b0;
            digital_rx_reg <= 1'b0;
        end else begin
            serial_out_reg <= serial_out_next;
            digital_rx_reg <= digital_rx_next;
        end
    end

    assign o_serial_switch_out_pin = serial_out_reg;
    assign o_digital_rx = digital_rx_reg;
endmodule : antenna_driver_output_select

// ---- dv/adrv_checker_props.sv ----
// Purpose: Port checks for the antenna driver output select block
// Assumes: Zero wait state APB, registered outputs, 8-bit address
// Notes: Bound to the design top below
`timescale 1ns/1ps
`include "adrv_consts.svh"

module adrv_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_antenna_out_first,
    input wire logic [`ADRV_P_COND_W-1:0] o_first_p_array_conductance,
    input wire logic [`ADRV_FRM_RATE_W-1:0] o_tx_rate,
    input wire logic [`ADRV_FRM_FRAMING_W-1:0] o_tx_framing
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic acc;
    logic bad;
    assign acc = i_psel && i_penable;
    assign bad = (i_paddr[1:0] != 2'h0) || (i_paddr > ADDR_W'(8'h1F));

    chk_ready_high: assert property (o_pready)
        else $error("pready low");
    chk_err_in_access: assert property (o_pslverr |-> acc)
        else $error("pslverr outside access");
    chk_err_unmapped: assert property (acc && bad |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_err_status_write: assert property (acc && i_pwrite && i_paddr == ADDR_W'(8'h1C) |-> o_pslverr)
        else $error("status write not refused");
    chk_read_upper_zero: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_rdata_hold: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
        else $error("read data moved outside setup");
    chk_framing_held: assert property (!(acc && i_pwrite) |=> $stable(o_tx_rate) && $stable(o_tx_framing))
        else $error("framing moved without write");
    chk_framing_write: assert property (acc && i_pwrite && i_paddr == ADDR_W'(8'h10)
        |=> o_tx_rate == $past(i_pwdata[6:4]) && o_tx_framing == $past(i_pwdata[1:0]))
        else $error("framing write lost");
    chk_reset_quiet: assert property ($rose(i_rst_n)
        |-> !o_antenna_out_first && o_first_p_array_conductance == 6'h00 && o_tx_rate == 3'h0)
        else $error("outputs active after reset");

    cov_write: cover property (acc && i_pwrite && !o_pslverr);
    cov_refused: cover property (acc && o_pslverr);
    cov_toggle: cover property (o_antenna_out_first ##1 !o_antenna_out_first);
endmodule : adrv_checker

bind antenna_driver_output_select adrv_checker #(.ADDR_W(ADDR_W)) i_adrv_checker (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_antenna_out_first(o_antenna_out_first), .o_first_p_array_conductance(o_first_p_array_conductance),
    .o_tx_rate(o_tx_rate), .o_tx_framing(o_tx_framing));

// ---- dv/mod_loop_model.sv ----
// Purpose: Crystal and external modulator at the far side of the block
// Assumes: Active antenna circuit echoes the serial output back
// Notes: Crystal runs free at 27.12 MHz
`timescale 1ns/1ps
module mod_loop_model (
    input wire logic i_serial_out,
    output logic o_serial_in,
    output logic o_xtal_clk
);
    initial o_xtal_clk = 1'b0;
    always #18.437 o_xtal_clk = ~o_xtal_clk;
    assign o_serial_in = i_serial_out;
endmodule : mod_loop_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the antenna driver output select block
// Assumes: APB master tasks, crystal and serial loop from the partner model
// Notes: Conductances CW 2A/B, modulation 15/4
`timescale 1ns/1ps
module tb;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic i_envelope = 1'b0;
    logic i_encoded_tx = 1'b0;
    logic i_analog_rx = 1'b0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, so, o_digital_rx, o1, o2, xtal, si;
    logic [5:0] p1, p2;
    logic [3:0] n1, n2;
    logic [2:0] o_tx_rate;
    logic [1:0] o_tx_framing;
    logic [31:0] rv;
    logic re;
    int fails = 0;
    int checks = 0;
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rst [7] = '{32'h0, 32'h3F, 32'h20, 32'h88, 32'h0, 32'h10, 32'h0};
    logic [3:0] sel [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5};
    always #2 i_mclk = ~i_mclk;

    antenna_driver_output_select i_antenna_driver_output_select (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_xtal_clk(xtal), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_envelope(i_envelope), .i_encoded_tx(i_encoded_tx), .i_analog_rx(i_analog_rx),
        .i_serial_switch_in_pin(si), .o_serial_switch_out_pin(so), .o_digital_rx(o_digital_rx),
        .o_antenna_out_first(o1), .o_antenna_out_second(o2), .o_first_p_array_conductance(p1),
        .o_first_n_array_conductance(n1), .o_second_p_array_conductance(p2),
        .o_second_n_array_conductance(n2), .o_tx_rate(o_tx_rate), .o_tx_framing(o_tx_framing));
    mod_loop_model i_mod_loop_model (.i_serial_out(so), .o_serial_in(si), .o_xtal_clk(xtal));

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : cyc

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 40);
        rv = o_prdata;
        re = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1) begin
            fails++;
            stop_test();
        end
        @(posedge i_mclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check("wr_err", re, 0);
    endtask : wr

    task automatic mode(input logic [7:0] c, input logic e, input logic a1, input logic a2, input int rel,
                        input logic [5:0] ep1, input logic [5:0] ep2, input logic [3:0] en1, input logic [3:0] en2);
        int t1, t2, eq;
        logic q1, q2;
        wr(8'h00, {24'h0, c});
        i_envelope <= e;
        cyc(4);
        check("p1", p1, ep1);
        check("p2", p2, ep2);
        check("n1", n1, en1);
        check("n2", n2, en2);
        t1 = 0;
        t2 = 0;
        eq = 0;
        q1 = o1;
        q2 = o2;
        repeat (184) begin
            @(posedge i_mclk);
            t1 += int'(o1 !== q1);
            t2 += int'(o2 !== q2);
            eq += int'(o1 === o2);
            q1 = o1;
            q2 = o2;
        end
        check("act1", a1 ? (t1 >= 19 && t1 <= 21) : (t1 == 0 && o1 === 1'b0), 1);
        check("act2", a2 ? (t2 >= 19 && t2 <= 21) : (t2 == 0 && o2 === 1'b0), 1);
        if (rel < 2) check("phase", eq, rel == 0 ? 184 : 0);
    endtask : mode

    initial begin
        cyc(4);
        i_rst_n <= 1'b1;
        cyc(1);
        foreach (ofs[k]) begin
            apb(1'b0, ofs[k], 32'h0);
            check("reset", rv, rst[k]);
        end
        $display("Test reset values done");
        apb(1'b1, 8'h1C, 32'hFF);
        check("status_wr", re, 1);
        apb(1'b1, 8'h11, 32'h53);
        check("misaligned", re, 1);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", {rv[30:0], re}, 1);
        apb(1'b0, 8'h10, 32'h0);
        check("untouched", rv, 0);
        $display("Test refused accesses done");
        wr(8'h10, 32'h53);
        cyc(1);
        check("rate_framing", {o_tx_rate, o_tx_framing}, 5'h17);
        wr(8'h04, 32'h2A);
        wr(8'h08, 32'h15);
        wr(8'h0C, 32'hB4);
        mode(8'h03, 1, 1, 1, 0, 6'h2A, 6'h2A, 4'hB, 4'hB);
        mode(8'h03, 0, 1, 1, 0, 6'h15, 6'h15, 4'h4, 4'h4);
        mode(8'h43, 1, 1, 1, 1, 6'h2A, 6'h2A, 4'hB, 4'hB);
        mode(8'h23, 0, 1, 1, 1, 6'h15, 6'h15, 4'h4, 4'h4);
        mode(8'h27, 0, 0, 0, 0, 6'h15, 6'h15, 4'h4, 4'h4);
        mode(8'h07, 1, 1, 1, 0, 6'h2A, 6'h2A, 4'hB, 4'hB);
        mode(8'h0F, 0, 0, 1, 2, 6'h15, 6'h2A, 4'h4, 4'hB);
        mode(8'h01, 1, 1, 0, 2, 6'h2A, 6'h00, 4'hB, 4'h0);
        mode(8'h02, 0, 0, 1, 2, 6'h00, 6'h15, 4'h0, 4'h4);
        mode(8'h00, 1, 0, 0, 0, 6'h00, 6'h00, 4'h0, 4'h0);
        $display("Test antenna modes done");
        wr(8'h00, 32'h01);
        i_envelope <= 1'b0;
        wr(8'h14, 32'h21);
        cyc(8);
        check("env_pin_hi", p1, 6'h2A);
        wr(8'h14, 32'h20);
        cyc(8);
        check("env_pin_lo", p1, 6'h15);
        wr(8'h14, 32'h00);
        cyc(4);
        check("env_const", p1, 6'h2A);
        for (int r = 0; r < 2; r++) begin
            i_envelope <= r[0];
            i_encoded_tx <= ~r[0];
            i_analog_rx <= r[0];
            foreach (sel[k]) begin
                wr(8'h14, {28'h1, sel[k]});
                cyc(2);
                check("out_pin", so, sel[k] == 4'h1 || (sel[k] == 4'h2 && i_envelope)
                    || (sel[k] == 4'h4 && i_encoded_tx) || (sel[k] == 4'h5 && i_analog_rx));
            end
            wr(8'h18, 32'h2);
            cyc(2);
            check("rx_analog", o_digital_rx, i_analog_rx);
        end
        wr(8'h18, 32'h1);
        wr(8'h14, 32'h11);
        cyc(8);
        check("rx_pin_hi", o_digital_rx, 1);
        wr(8'h14, 32'h10);
        cyc(8);
        check("rx_pin_lo", o_digital_rx, 0);
        wr(8'h18, 32'h0);
        cyc(2);
        check("rx_low", o_digital_rx, 0);
        $display("Test serial switch done");
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped_rd", {rv[30:0], re}, 1);
        apb(1'b0, 8'h1C, 32'h0);
        check("status", rv & 32'hFFFF_FFF9, 32'h51);
        $display("Test late reads done");
        stop_test();
    end
endmodule : tb
